// ===== hw/gpgc_pkg.sv
// gpgc_pkg: register map, field layout and carrier types of the pin group controller
// assumes one group of up to 32 pins per instance, word registers on Avalon-MM
package gpgc_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] GPGC_OFS_DRIVE_EN = 8'h00;
  localparam logic [7:0] GPGC_OFS_DRIVE_EN_CLR = 8'h04;
  localparam logic [7:0] GPGC_OFS_DRIVE_EN_SET = 8'h08;
  localparam logic [7:0] GPGC_OFS_DRIVE_EN_FLIP = 8'h0C;
  localparam logic [7:0] GPGC_OFS_LEVEL = 8'h10;
  localparam logic [7:0] GPGC_OFS_LEVEL_CLR = 8'h14;
  localparam logic [7:0] GPGC_OFS_LEVEL_SET = 8'h18;
  localparam logic [7:0] GPGC_OFS_LEVEL_FLIP = 8'h1C;
  localparam logic [7:0] GPGC_OFS_SAMPLE = 8'h20;
  localparam logic [7:0] GPGC_OFS_CTRL = 8'h24;
  localparam logic [7:0] GPGC_OFS_SELECT = 8'h30;
  localparam logic [7:0] GPGC_OFS_PADCFG = 8'h40;
  // ----------------------------------------
  // field positions inside pad_config_y and select bytes
  // ----------------------------------------
  localparam int GPGC_CFG_ROUTE_BIT = 0;
  localparam int GPGC_CFG_SAMPLE_BIT = 1;
  localparam int GPGC_CFG_PULL_BIT = 2;
  localparam int GPGC_SEL_W = 4;
  localparam logic [3:0] GPGC_SEL_ANALOG = 4'h1;
  localparam logic [31:0] GPGC_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] GPGC_RST_BYTE = 8'h00;
  localparam int GPGC_SYNC_DELAY = 2;
  // ----------------------------------------
  // local port carrier
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byteen;
    logic [31:0] wdata;
  } gpgc_local_req_s;
  typedef struct packed {
    logic [31:0] drive_en;
    logic [31:0] level;
  } gpgc_pins_s;
endpackage

// ===== hw/gpgc_ctrl.sv
// gpgc_ctrl: one pin group of the general purpose pin controller
// assumes MCLK is the core clock; Avalon and local port share it; pads sit outside
`timescale 1ns/100ps
// How it works
// - reset leaves all pins input, everything disabled
// - registers and synchronizers reset, never restored
// - local port beats Avalon and events
// - synchronizers run on the main clock
// - local port single cycle, byte/half/word
// - local port reaches direction, level, sample
// - direction bit one means output
// - output drives the level bit value
// - sample tracks pad; off when disabled
// - route enable hands pad to peripheral
// - after reset pads tri-stated, buffers off
// - one register set per group, bit per pin
// - direction set alias sets ones only
// - direction clear alias clears ones only
// - level set, clear, flip aliases
// - on-demand read waits three extra cycles
// - always-sample bit per eight pins
// - pad config byte at offset y
// - select byte per pin pair, odd/even
// - analog function kills digital pad features
// - guard protects Avalon and local port writes unless debug halted; event flips pass
module gpgc_ctrl import gpgc_pkg::*; #(
  parameter int PINS = 32
) (
  input wire logic MCLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // core local port, never stalls
  input wire gpgc_local_req_s LOCAL_REQ,
  output logic [31:0] LOCAL_RDATA,
  // event router write of the level register
  input wire logic EVT_VALID,
  input wire logic [31:0] EVT_FLIP,
  output logic EVT_READY,
  // access guard and debug halt
  input wire logic GUARD_PROTECT,
  input wire logic DEBUG_HALT,
  // pads
  input wire logic [PINS-1:0] PAD_IN,
  output logic [PINS-1:0] PAD_OUT,
  output logic [PINS-1:0] PAD_OE,
  output logic [PINS-1:0] PAD_IE,
  output logic [PINS-1:0] PAD_PULL,
  // peripheral side
  input wire logic [PINS-1:0] PERIPH_OUT,
  input wire logic [PINS-1:0] PERIPH_OE,
  output logic [PINS-1:0] PERIPH_IN,
  output logic [PINS*GPGC_SEL_W-1:0] PERIPH_SEL
);
  localparam int GROUPS = (PINS + 7) / 8;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [PINS-1:0] drive_en;         // direction, 1 = output
    logic [PINS-1:0] level;            // drive level
    logic [PINS-1:0][7:0] cfg;         // pad_config_y bytes
    logic [PINS-1:0][GPGC_SEL_W-1:0] sel; // periph_select per pin
    logic [GROUPS-1:0] always_sync;    // always_sync_group_n
    logic [PINS-1:0] s1, s2, s3;       // three stage synchronizer
    logic [PINS-1:0] sample;           // settled pad value
    logic [1:0] wait_cnt;              // on-demand read wait
    logic busy;                        // on-demand sample read in progress
    logic done;                        // answer cycle
    logic [31:0] rdata;                // avalon read data
    logic [31:0] lrdata;               // local port read data
  } gpgc_state_s;

  gpgc_state_s st_reg, st_next;

  logic av_req, wr_ok, av_hit, need_wait, evt_go;
  logic [PINS-1:0] sync_clk, pin_digital;
  logic [31:0] bmask, lmask, lval, aval;

  // byte enables to bit mask
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // direction and level register update from one access
  function automatic logic [31:0] apply(input logic [31:0] cur, input logic [7:0] ofs,
                                        input logic [7:0] base, input logic [31:0] d,
                                        input logic [31:0] m);
    logic [31:0] r;
    r = cur;
    // zero bits of alias writes leave bits alone
    if (ofs == base) r = (cur & ~m) | (d & m);
    else if (ofs == base + 8'h04) r = cur & ~(d & m);
    else if (ofs == base + 8'h08) r = cur | (d & m);
    else if (ofs == base + 8'h0C) r = cur ^ (d & m);
    apply = r;
  endfunction

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // write protection lifted in debug halt
    wr_ok = !GUARD_PROTECT || DEBUG_HALT;
    // local port wins every collision
    av_req = (AVS_READ || AVS_WRITE) && !LOCAL_REQ.valid && !st_reg.done;
    evt_go = EVT_VALID && !LOCAL_REQ.valid;
    EVT_READY = evt_go;
    bmask = lanes(AVS_BYTEENABLE);
    lmask = lanes(LOCAL_REQ.byteen);
    lval = 32'h0000_0000;
    aval = 32'h0000_0000;
    av_hit = 1'b0;
    st_next.done = 1'b0;
    // synchronizer enable per pin, main clock only
    for (int p = 0; p < PINS; p++) begin
      sync_clk[p] = st_reg.cfg[p][GPGC_CFG_SAMPLE_BIT] &&
        (st_reg.always_sync[p/8] || st_reg.busy);
      pin_digital[p] = st_reg.sel[p] != GPGC_SEL_ANALOG ||
        !st_reg.cfg[p][GPGC_CFG_ROUTE_BIT];
    end
    need_wait = (st_reg.always_sync != {GROUPS{1'b1}});
    for (int p = 0; p < PINS; p++) begin
      if (sync_clk[p]) begin
        st_next.s1[p] = PAD_IN[p];
        st_next.s2[p] = st_reg.s1[p];
        st_next.s3[p] = st_reg.s2[p];
        // change counts once second and third agree
        if (st_reg.s2[p] == st_reg.s3[p]) st_next.sample[p] = st_reg.s3[p];
      end
    end
    // local port: single cycle, any size
    if (LOCAL_REQ.valid && LOCAL_REQ.write && wr_ok) begin
      st_next.drive_en = apply(st_reg.drive_en, LOCAL_REQ.addr, GPGC_OFS_DRIVE_EN,
                               LOCAL_REQ.wdata, lmask);
      st_next.level = apply(st_reg.level, LOCAL_REQ.addr, GPGC_OFS_LEVEL,
                            LOCAL_REQ.wdata, lmask);
    end
    if (LOCAL_REQ.valid && !LOCAL_REQ.write) begin
      // sample read returns current value, no wait
      unique case (LOCAL_REQ.addr)
        GPGC_OFS_DRIVE_EN: lval = 32'(st_reg.drive_en);
        GPGC_OFS_LEVEL: lval = 32'(st_reg.level);
        GPGC_OFS_SAMPLE: lval = 32'(st_reg.sample);
        default: lval = 32'h0000_0000;
      endcase
      st_next.lrdata = lval & lmask;
    end
    // avalon register file
    if (av_req && AVS_READ) begin
      for (int p = 0; p < PINS; p++) begin
        // pad config byte y at offset y
        if (AVS_ADDRESS[7:2] == GPGC_OFS_PADCFG[7:2] + 6'(p/4))
          aval[(p%4)*8 +: 8] = st_reg.cfg[p];
        // select byte y/2: even low nibble, odd high nibble
        if (AVS_ADDRESS[7:2] == GPGC_OFS_SELECT[7:2] + 6'(p/8))
          aval[(p%8)*4 +: 4] = st_reg.sel[p];
      end
      unique case (AVS_ADDRESS)
        GPGC_OFS_DRIVE_EN, GPGC_OFS_DRIVE_EN_CLR, GPGC_OFS_DRIVE_EN_SET,
        GPGC_OFS_DRIVE_EN_FLIP: aval = 32'(st_reg.drive_en);
        GPGC_OFS_LEVEL, GPGC_OFS_LEVEL_CLR, GPGC_OFS_LEVEL_SET,
        GPGC_OFS_LEVEL_FLIP: aval = 32'(st_reg.level);
        GPGC_OFS_SAMPLE: aval = 32'(st_reg.sample);
        GPGC_OFS_CTRL: aval = 32'(st_reg.always_sync);
        default: av_hit = 1'b0;
      endcase
      // on-demand: sample read held three extra cycles
      if (AVS_ADDRESS == GPGC_OFS_SAMPLE && need_wait && !st_reg.busy) begin
        st_next.busy = 1'b1;
        st_next.wait_cnt = 2'(GPGC_SYNC_DELAY);
      end else if (st_reg.busy && st_reg.wait_cnt != 2'd0) begin
        st_next.wait_cnt = st_reg.wait_cnt - 2'd1;
      end else begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.rdata = aval;
      end
    end
    if (av_req && AVS_WRITE) begin
      st_next.done = 1'b1;
      if (wr_ok) begin
        st_next.drive_en = apply(st_reg.drive_en, AVS_ADDRESS, GPGC_OFS_DRIVE_EN,
                                 AVS_WRITEDATA, bmask);
        st_next.level = apply(st_reg.level, AVS_ADDRESS, GPGC_OFS_LEVEL,
                              AVS_WRITEDATA, bmask);
        if (AVS_ADDRESS == GPGC_OFS_CTRL)
          st_next.always_sync = (st_reg.always_sync & ~bmask[GROUPS-1:0]) |
            (AVS_WRITEDATA[GROUPS-1:0] & bmask[GROUPS-1:0]);
        for (int p = 0; p < PINS; p++) begin
          if (AVS_ADDRESS[7:2] == GPGC_OFS_PADCFG[7:2] + 6'(p/4) && AVS_BYTEENABLE[p%4])
            st_next.cfg[p] = AVS_WRITEDATA[(p%4)*8 +: 8];
          if (AVS_ADDRESS[7:2] == GPGC_OFS_SELECT[7:2] + 6'(p/8) &&
              AVS_BYTEENABLE[(p%8)/2])
            st_next.sel[p] = AVS_WRITEDATA[(p%8)*4 +: 4];
        end
      end
    end
    // event router flips level bits when the local port is idle; it is applied
    // on top of any avalon write of the same cycle so neither update is lost
    if (evt_go) st_next.level = st_next.level ^ EVT_FLIP[PINS-1:0];
    AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st_reg.done;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // full reset, nothing kept across power down
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // pad drive, one bit per pin
  // ----------------------------------------
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      if (st_reg.cfg[p][GPGC_CFG_ROUTE_BIT]) begin
        // peripheral owns the pad
        PAD_OUT[p] = PERIPH_OUT[p];
        PAD_OE[p] = PERIPH_OE[p] && pin_digital[p];
        PAD_IE[p] = pin_digital[p]; // analog disables digital
        PAD_PULL[p] = 1'b0;
      end else begin
        // direction and level drive the pad
        PAD_OUT[p] = st_reg.level[p];
        PAD_OE[p] = st_reg.drive_en[p];
        PAD_IE[p] = st_reg.cfg[p][GPGC_CFG_SAMPLE_BIT];
        PAD_PULL[p] = st_reg.cfg[p][GPGC_CFG_PULL_BIT] && !st_reg.drive_en[p];
      end
      PERIPH_IN[p] = PAD_IN[p] && st_reg.cfg[p][GPGC_CFG_ROUTE_BIT] && pin_digital[p];
      PERIPH_SEL[p*GPGC_SEL_W +: GPGC_SEL_W] = st_reg.sel[p];
    end
    AVS_READDATA = st_reg.rdata;
    LOCAL_RDATA = st_reg.lrdata;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reset_all_input: assert property (@(posedge MCLK) !RST_N |=> PAD_OE == '0 && PAD_IE == '0)
    else $error("pads not idle after reset");
  a_local_over_av: assert property (@(posedge MCLK) disable iff (!RST_N)
    LOCAL_REQ.valid && !st_reg.done && (AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("avalon not stalled by local port");
  a_local_set_dir: assert property (@(posedge MCLK) disable iff (!RST_N)
    LOCAL_REQ.valid && LOCAL_REQ.write && wr_ok && LOCAL_REQ.addr == GPGC_OFS_DRIVE_EN_SET
    |=> (st_reg.drive_en & $past(LOCAL_REQ.wdata & lmask)) == $past(LOCAL_REQ.wdata & lmask))
    else $error("direction set lost");
  a_local_clr_dir: assert property (@(posedge MCLK) disable iff (!RST_N)
    LOCAL_REQ.valid && LOCAL_REQ.write && wr_ok && LOCAL_REQ.addr == GPGC_OFS_DRIVE_EN_CLR
    |=> (st_reg.drive_en & $past(LOCAL_REQ.wdata & lmask)) == '0)
    else $error("direction clear lost");
  a_dir_drives_oe: assert property (@(posedge MCLK) disable iff (!RST_N)
    !st_reg.cfg[0][GPGC_CFG_ROUTE_BIT] |-> PAD_OE[0] == st_reg.drive_en[0]
    && PAD_OUT[0] == st_reg.level[0])
    else $error("pad 0 drive mismatch");
  a_ondemand_wait: assert property (@(posedge MCLK) disable iff (!RST_N)
    AVS_READ && !AVS_WAITREQUEST == 1'b0 && !st_reg.busy && !st_reg.done && !LOCAL_REQ.valid
    && AVS_ADDRESS == GPGC_OFS_SAMPLE && need_wait |=> AVS_WAITREQUEST[*2])
    else $error("on-demand read not delayed");
  a_guard_blocks: assert property (@(posedge MCLK) disable iff (!RST_N)
    GUARD_PROTECT && !DEBUG_HALT && !evt_go |=> st_reg.level == $past(st_reg.level))
    else $error("protected write took effect");
  a_route_hands: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_reg.cfg[0][GPGC_CFG_ROUTE_BIT] && pin_digital[0] |-> PAD_OUT[0] == PERIPH_OUT[0])
    else $error("peripheral route broken");
endmodule

// ===== tb/gpgc_pad_model.sv
// gpgc_pad_model: the pads and the board around one pin group
// assumes the bench supplies the level the board puts on undriven pads
`timescale 1ns/100ps
module gpgc_pad_model (
  input wire logic [31:0] PAD_OUT,
  input wire logic [31:0] PAD_OE,
  input wire logic [31:0] PAD_PULL,
  input wire logic [31:0] EXT,
  output logic [31:0] PAD_IN
);
  // ----------------------------------------
  // pad level
  // ----------------------------------------
  // a driven pad reads back its own level, a pulled one its pull level,
  // a floating one the board value, which the bench sets once
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      PAD_IN[i] = (PAD_OE[i] | PAD_PULL[i]) ? PAD_OUT[i] : EXT[i];
    end
  end
endmodule

// ===== tb/gpgc_ctrl_bench.sv
// gpgc_ctrl_bench: self-checking bench of one pin group controller
// assumes one 32-pin group, Avalon master and local port driven here
`timescale 1ns/100ps
module gpgc_ctrl_bench import gpgc_pkg::*;;
  logic mclk, rst_n, av_rd, av_wr, av_wait, evt_valid, evt_ready, guard, halt;
  logic [7:0] av_addr;
  logic [3:0] av_be;
  logic [31:0] av_wd, av_rdata, loc_rdata, evt_flip, pad_in, pad_out, pad_oe, pad_ie;
  logic [31:0] pad_pull, ext, p_out, p_oe, p_in, de, lv, m, rd;
  logic [127:0] p_sel;
  logic [15:0] seed;
  gpgc_local_req_s loc_req;
  int n_mismatch, samples_checked, av_k;
  gpgc_ctrl uut (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
    .AVS_WRITE(av_wr), .AVS_BYTEENABLE(av_be), .AVS_WRITEDATA(av_wd),
    .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .LOCAL_REQ(loc_req),
    .LOCAL_RDATA(loc_rdata), .EVT_VALID(evt_valid), .EVT_FLIP(evt_flip),
    .EVT_READY(evt_ready), .GUARD_PROTECT(guard), .DEBUG_HALT(halt), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_IE(pad_ie), .PAD_PULL(pad_pull),
    .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .PERIPH_IN(p_in), .PERIPH_SEL(p_sel));
  gpgc_pad_model pads (.PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULL(pad_pull),
    .EXT(ext), .PAD_IN(pad_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected register after a plain, clear, set or flip write
  function automatic logic [31:0] upd(input int op, input logic [31:0] o, input logic [31:0] w);
    return op == 0 ? w : op == 1 ? o & ~w : op == 2 ? o | w : o ^ w;
  endfunction
  task automatic rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v[15:0] = seed;
    seed = lfsr(seed);
    v[31:16] = seed;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one Avalon cycle; held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] r);
    av_addr <= a;
    av_be <= be;
    av_wd <= d;
    av_wr <= w;
    av_rd <= !w;
    av_k = 0;
    do begin
      @(posedge mclk);
      av_k++;
    end while (av_wait !== 1'b0 && av_k < 60);
    if (av_k >= 60) n_mismatch++;
    r = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge mclk);
  endtask
  // one local port access; read data comes one cycle after the take
  task automatic lo(input logic w, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] r);
    loc_req <= '{1'b1, w, a, be, d};
    @(posedge mclk);
    loc_req <= '0;
    @(posedge mclk);
    r = loc_rdata;
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst_n, av_rd, av_wr, evt_valid, guard, halt, av_addr, av_be} = '0;
    {av_wd, evt_flip, ext, p_out, p_oe} = '0;
    loc_req = '0;
    seed = 16'h55de;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(pad_oe | pad_ie | pad_pull, 32'h0000_0000);
    av(0, GPGC_OFS_DRIVE_EN, 4'hf, 0, rd);
    chk(rd, GPGC_RST_WORD);
    $display("reset test done");
    de = 0;
    lv = 0;
    for (int i = 0; i < 12; i++) begin
      rnd(m);
      av(1, GPGC_OFS_DRIVE_EN + 8'(4 * (i % 4)), 4'hf, m, rd);
      de = upd(i % 4, de, m);
      rnd(m);
      lo(1, GPGC_OFS_LEVEL + 8'(4 * (i % 4)), 4'hf, m, rd);
      lv = upd(i % 4, lv, m);
      av(0, GPGC_OFS_DRIVE_EN, 4'hf, 0, rd);
      chk(rd, de);
      lo(0, GPGC_OFS_LEVEL, 4'hf, 0, rd);
      chk(rd, lv);
      chk(pad_oe, de);
      chk(pad_out & de, lv & de);
    end
    lo(1, GPGC_OFS_LEVEL_SET, 4'h2, 32'hffff_ffff, rd);
    lv = lv | 32'h0000_ff00;
    lo(0, GPGC_OFS_LEVEL, 4'hf, 0, rd);
    chk(rd, lv);
    $display("alias test done");
    for (int i = 0; i < 8; i++) av(1, GPGC_OFS_PADCFG + 8'(4 * i), 4'hf, 32'h0202_0202, rd);
    av(1, GPGC_OFS_CTRL, 4'hf, 32'h0000_000f, rd);
    rnd(m);
    ext <= m;
    repeat (4) @(posedge mclk);
    av(0, GPGC_OFS_SAMPLE, 4'hf, 0, rd);
    chk(rd, (de & lv) | (~de & m));
    lo(0, GPGC_OFS_SAMPLE, 4'hf, 0, rd);
    chk(rd, (de & lv) | (~de & m));
    av(1, GPGC_OFS_CTRL, 4'hf, 32'h0000_0000, rd);
    av(0, GPGC_OFS_SAMPLE, 4'hf, 0, rd);
    chk(rd, (de & lv) | (~de & m));
    chk(32'(av_k), 32'(GPGC_SYNC_DELAY + 3));
    $display("sample test done");
    rnd(p_out);
    rnd(p_oe);
    av(1, GPGC_OFS_PADCFG, 4'h1, 32'h0000_0003, rd);
    av(1, GPGC_OFS_PADCFG + 8'h04, 4'h2, 32'h0000_0700, rd);
    av(1, GPGC_OFS_SELECT, 4'h5, 32'h0010_0052, rd);
    chk({p_oe[0], p_out[0]}, {pad_oe[0], pad_out[0]});
    chk(p_in[0], pad_in[0]);
    chk(p_sel[31:0], 32'h0010_0052);
    chk({pad_ie[5], pad_oe[5], pad_pull[5]}, 3'h0);
    $display("routing test done");
    guard <= 1'b1;
    av(1, GPGC_OFS_DRIVE_EN, 4'hf, ~de, rd);
    av(0, GPGC_OFS_DRIVE_EN, 4'hf, 0, rd);
    chk(rd, de);
    halt <= 1'b1;
    av(1, GPGC_OFS_DRIVE_EN, 4'hf, ~de, rd);
    av(0, GPGC_OFS_DRIVE_EN, 4'hf, 0, rd);
    chk(rd, ~de);
    $display("guard test done");
    rnd(m);
    fork
      av(1, GPGC_OFS_LEVEL_FLIP, 4'hf, m, rd);
      lo(1, GPGC_OFS_LEVEL_SET, 4'hf, 32'h0000_0001, de);
    join
    lv = (lv | 32'h0000_0001) ^ m;
    rnd(m);
    evt_valid <= 1'b1;
    evt_flip <= m;
    do @(posedge mclk); while (evt_ready !== 1'b1);
    evt_valid <= 1'b0;
    lv = lv ^ m;
    @(posedge mclk);
    lo(0, GPGC_OFS_LEVEL, 4'hf, 0, rd);
    chk(rd, lv);
    $display("priority test done");
    final_report();
  end
endmodule
